// [hdl/pocfg_consts.svh]
// constants for the pulse output origin search configuration block
// Function
// RULE1: channel 0 takes its limit input sense from bits 3:0 of the sensor word, 0 for normally closed and 1 for normally open, latched at operation start.
// RULE2: channel 0 takes its origin proximity input sense from bits 7:4 of the sensor word, 0 closed and 1 open, latched at operation start.
// RULE3: channel 0 takes its origin input sense from bits 11:8 of the sensor word, 0 closed and 1 open, latched at operation start.
// RULE4: bits 15:12 of the sensor word choose whether a limit hit during a search or pulse output keeps the origin (0) or undefines it (1).
// RULE5: channel 0 takes a monitor time of 0 to 9999 ms, codes 0000 to 270f hex, default zero, latched at operation start.
// RULE6: bits 3:0 of the channel 1 word enable (1) or disable (0) the channel 1 origin search, sampled only at power-on.
// RULE7: while channel 1 origin search is enabled, interrupt inputs 2 and 3 and pulse-width output 1 are withheld, and high-speed counters 0 and 1 stay usable.
// RULE8: bits 7:4 of the channel 1 word make the limits act only during origin searches (0) or for every pulse output function (1), sampled at power-on.
// RULE9: the present states of both limit inputs of both channels are mirrored into status bits that software can read.
// RULE10: the channel 1 enable and limit scope are captured only at power-up and later writes have no effect until the next power-up.
// RULE11: a normally closed input counts as active when its raw level is low, so an open circuit reads as triggered.
`ifndef POCFG_CONSTS_SVH
`define POCFG_CONSTS_SVH

// -----------------------------------------------------------------------------
// register word indices (byte address is four times the index)
// -----------------------------------------------------------------------------
`define POCFG_IDX_CH0_SENSE 10'h10c
`define POCFG_IDX_CH0_MON   10'h10d
`define POCFG_IDX_CH1_FUNC  10'h112
`define POCFG_IDX_STATUS    10'h120

// -----------------------------------------------------------------------------
// field positions and values
// -----------------------------------------------------------------------------
`define POCFG_F_LIM      0
`define POCFG_F_PROX     4
`define POCFG_F_ORG      8
`define POCFG_F_UNDEF    12
`define POCFG_F_EN       0
`define POCFG_F_SCOPE    4
`define POCFG_FLD_ONE    4'h1
`define POCFG_S_CH0_CW   0
`define POCFG_S_CH0_CCW  1
`define POCFG_S_CH1_CW   2
`define POCFG_S_CH1_CCW  3
`define POCFG_S_ORG_DEF  4
`define POCFG_S_CH1_EN   5
`define POCFG_S_CH1_ALW  6
`define POCFG_S_MON_ERR  7

// -----------------------------------------------------------------------------
// reset values and timing
// -----------------------------------------------------------------------------
`define POCFG_CH0_SENSE_RST 16'h0000
`define POCFG_CH0_MON_RST   16'h0000
`define POCFG_CH1_FUNC_RST  16'h0000
`define POCFG_MON_MAX       16'h270f
`define POCFG_CLK_PERIOD_NS 5
`define POCFG_MON_UNIT_NS   1000000

`endif

// [hdl/pocfg_pkg.sv]
// types for the pulse output origin search configuration block
package pocfg_pkg;
   typedef enum logic [1:0] {
      MON_IDLE = 2'b01,
      MON_WAIT = 2'b10
   } pocfg_mon_state_t;
endpackage : pocfg_pkg

// [hdl/pocfg_sync.sv]
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
`default_nettype none
module pocfg_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rstn,
   // data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   initial begin
      if (W < 1) $error("pocfg_sync: W must be at least 1");
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : pocfg_sync
`default_nettype wire

// [hdl/pocfg_sense.sv]
// applies normally open or normally closed sense to a group of inputs
`timescale 1ns/100ps
`default_nettype none
module pocfg_sense #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rstn,
   // data
   input  wire logic [W-1:0] raw,
   input  wire logic [W-1:0] open_sense,
   output logic      [W-1:0] active
);
   initial begin
      if (W < 1) $error("pocfg_sense: W must be at least 1");
   end

   // closed-sense inputs invert, so a broken wire reads as triggered
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         active <= '0;
      end else begin
         active <= ~(raw ^ open_sense); // [RULE11]
      end
   end
endmodule : pocfg_sense
`default_nettype wire

// [hdl/pocfg_top.sv]
// origin search configuration, sensor sense and status for pulse outputs 0 and 1
//
// The Wishbone slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "pocfg_consts.svh"
module pocfg_top
   import pocfg_pkg::*;
#(
   parameter int          MS_CYCLES       = `POCFG_MON_UNIT_NS / `POCFG_CLK_PERIOD_NS,
   parameter logic [15:0] CH1_POWERON_CFG = `POCFG_CH1_FUNC_RST,
   parameter bit          CH1_LIMIT_OPEN  = 1'b1
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [11:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // sensor pins
   input  wire logic        ch0_cw_lim_pin,
   input  wire logic        ch0_ccw_lim_pin,
   input  wire logic        ch0_prox_pin,
   input  wire logic        ch0_origin_pin,
   input  wire logic        ch0_inpos_pin,
   input  wire logic        ch1_cw_lim_pin,
   input  wire logic        ch1_ccw_lim_pin,
   // pulse engine, same clock
   input  wire logic        ch0_op_start,
   input  wire logic        ch0_busy,
   input  wire logic        ch0_origin_found,
   input  wire logic        ch0_pos_done,
   input  wire logic        ch1_search_req,
   input  wire logic        ch1_search_busy,
   // sensor states after sense
   output logic             ch0_cw_lim_act,
   output logic             ch0_ccw_lim_act,
   output logic             ch0_prox_act,
   output logic             ch0_origin_act,
   // origin and monitor state
   output logic             ch0_origin_defined,
   output logic             ch0_mon_error,
   // channel 1 control
   output logic             ch1_search_go,
   output logic             ch1_lim_stop,
   // shared resource permissions
   output logic             irq23_allow,
   output logic             pwm1_allow,
   output logic             hsc01_allow
);
   // -----------------------------------------------------------------------------
   // elaboration checks and derived constants
   // -----------------------------------------------------------------------------
   localparam int          MS_W    = (MS_CYCLES > 2) ? $clog2(MS_CYCLES) : 1;
   localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_CYCLES - 1);

   initial begin
      if (MS_CYCLES < 2) $error("pocfg_top: MS_CYCLES must be at least 2");
   end

   // -----------------------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------------------
   logic [15:0]      ch0_sense_q;
   logic [15:0]      ch0_mon_q;
   logic [15:0]      ch1_func_q;
   logic [15:0]      ch0_sense_act_q;
   logic [15:0]      ch0_mon_act_q;
   logic [15:0]      ch1_func_act_q;
   logic             init_done_q;
   logic             ack_q;
   logic [31:0]      rd_q;
   logic [31:0]      rd_d;
   logic             req;
   logic             wr_take;
   logic [9:0]       widx;
   logic [6:0]       pins_s;
   logic [3:0]       ch0_act;
   logic [1:0]       ch1_act;
   logic             ch0_inpos_s;
   logic             lim_open0;
   logic             prox_open0;
   logic             org_open0;
   logic             undef0;
   logic             ch1_en;
   logic             ch1_always;
   logic             origin_def_q;
   logic             mon_err_q;
   logic             ch1_stop_q;
   logic             ch0_limit_hit;
   logic             mon_expire;
   logic             mon_err_clr;
   logic [15:0]      mon_clamped;
   logic [15:0]      status_w;
   pocfg_mon_state_t mon_state_q;
   logic [MS_W-1:0]  ms_cnt_q;
   logic [15:0]      elapsed_q;

   // -----------------------------------------------------------------------------
   // pin synchronisers and sense
   // -----------------------------------------------------------------------------
   pocfg_sync #(.W(7)) u_sync (
      .core_clk (core_clk),
      .rstn     (rstn),
      .async_in ({ch1_ccw_lim_pin, ch1_cw_lim_pin, ch0_inpos_pin, ch0_origin_pin,
                  ch0_prox_pin, ch0_ccw_lim_pin, ch0_cw_lim_pin}),
      .sync_out (pins_s)
   );

   assign lim_open0  = (ch0_sense_act_q[`POCFG_F_LIM+:4] == `POCFG_FLD_ONE);   // [RULE1]
   assign prox_open0 = (ch0_sense_act_q[`POCFG_F_PROX+:4] == `POCFG_FLD_ONE);  // [RULE2]
   assign org_open0  = (ch0_sense_act_q[`POCFG_F_ORG+:4] == `POCFG_FLD_ONE);   // [RULE3]
   assign undef0     = (ch0_sense_act_q[`POCFG_F_UNDEF+:4] == `POCFG_FLD_ONE); // [RULE4]
   assign ch1_en     = (ch1_func_act_q[`POCFG_F_EN+:4] == `POCFG_FLD_ONE);     // [RULE6]
   assign ch1_always = (ch1_func_act_q[`POCFG_F_SCOPE+:4] == `POCFG_FLD_ONE);  // [RULE8]
   assign ch0_inpos_s = pins_s[4];

   pocfg_sense #(.W(4)) u_sense0 (
      .core_clk   (core_clk),
      .rstn       (rstn),
      .raw        (pins_s[3:0]),
      .open_sense ({org_open0, prox_open0, lim_open0, lim_open0}),
      .active     (ch0_act)
   );

   pocfg_sense #(.W(2)) u_sense1 (
      .core_clk   (core_clk),
      .rstn       (rstn),
      .raw        (pins_s[6:5]),
      .open_sense ({CH1_LIMIT_OPEN, CH1_LIMIT_OPEN}),
      .active     (ch1_act)
   );

   assign ch0_cw_lim_act  = ch0_act[0];
   assign ch0_ccw_lim_act = ch0_act[1];
   assign ch0_prox_act    = ch0_act[2];
   assign ch0_origin_act  = ch0_act[3];

   // -----------------------------------------------------------------------------
   // wishbone slave: ack one cycle after the request, dropped the cycle after
   // -----------------------------------------------------------------------------
   assign req     = wb_cyc_i & wb_stb_i;
   assign wr_take = req & wb_we_i & ack_q;
   assign widx    = wb_adr_i[11:2];

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
      merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction : merge

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   assign status_w = {8'h00, mon_err_q, ch1_always, ch1_en, origin_def_q,
                      ch1_act[1], ch1_act[0], ch0_act[1], ch0_act[0]}; // [RULE9]

   // unmapped words read as zero and ignore writes
   always_comb begin
      rd_d = 32'h0000_0000;
      case (widx)
         `POCFG_IDX_CH0_SENSE: rd_d = {16'h0000, ch0_sense_q};
         `POCFG_IDX_CH0_MON:   rd_d = {16'h0000, ch0_mon_q};
         `POCFG_IDX_CH1_FUNC:  rd_d = {16'h0000, ch1_func_q};
         `POCFG_IDX_STATUS:    rd_d = {16'h0000, status_w};
         default:              rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rd_q <= 32'h0000_0000;
      end else if (req & ~ack_q) begin
         rd_q <= rd_d;
      end
   end

   assign wb_dat_o = rd_q;
   assign wb_ack_o = ack_q;

   // -----------------------------------------------------------------------------
   // software-visible setting words
   // -----------------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ch0_sense_q <= `POCFG_CH0_SENSE_RST;
         ch0_mon_q   <= `POCFG_CH0_MON_RST;
      end else if (wr_take) begin
         if (widx == `POCFG_IDX_CH0_SENSE) ch0_sense_q <= merge(ch0_sense_q, wb_dat_i, wb_sel_i);
         if (widx == `POCFG_IDX_CH0_MON)   ch0_mon_q   <= merge(ch0_mon_q, wb_dat_i, wb_sel_i);
      end
   end

   // the stored word stands for the retained setting seen at power-up
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ch1_func_q <= CH1_POWERON_CFG;
      end else if (wr_take && widx == `POCFG_IDX_CH1_FUNC) begin
         ch1_func_q <= merge(ch1_func_q, wb_dat_i, wb_sel_i);
      end
   end

   // -----------------------------------------------------------------------------
   // active copies: channel 0 at operation start, channel 1 once after power-up
   // -----------------------------------------------------------------------------
   // out-of-range monitor codes saturate rather than wrap to a short time
   assign mon_clamped = (ch0_mon_q > `POCFG_MON_MAX) ? `POCFG_MON_MAX : ch0_mon_q;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ch0_sense_act_q <= `POCFG_CH0_SENSE_RST;
         ch0_mon_act_q   <= `POCFG_CH0_MON_RST;
      end else if (ch0_op_start) begin
         ch0_sense_act_q <= ch0_sense_q; // [RULE1] [RULE2] [RULE3] [RULE4]
         ch0_mon_act_q   <= mon_clamped; // [RULE5]
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ch1_func_act_q <= `POCFG_CH1_FUNC_RST;
         init_done_q    <= 1'b0;
      end else if (!init_done_q) begin
         ch1_func_act_q <= ch1_func_q; // [RULE6] [RULE8] [RULE10]
         init_done_q    <= 1'b1;
      end
   end

   // -----------------------------------------------------------------------------
   // channel 0 origin hold or undefine
   // -----------------------------------------------------------------------------
   assign ch0_limit_hit = ch0_busy & (ch0_act[0] | ch0_act[1]);

   // a newly found origin wins over a simultaneous limit hit
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         origin_def_q <= 1'b0;
      end else if (ch0_origin_found) begin
         origin_def_q <= 1'b1;
      end else if (ch0_limit_hit && undef0) begin
         origin_def_q <= 1'b0; // [RULE4]
      end
   end

   assign ch0_origin_defined = origin_def_q;

   // -----------------------------------------------------------------------------
   // channel 0 positioning monitor
   // -----------------------------------------------------------------------------
   assign mon_expire = (mon_state_q == MON_WAIT) & ~ch0_inpos_s & (ms_cnt_q == MS_LAST)
                     & ((elapsed_q + 16'h0001) == ch0_mon_act_q);

   // a zero monitor time disables the check
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mon_state_q <= MON_IDLE;
         ms_cnt_q    <= '0;
         elapsed_q   <= 16'h0000;
      end else begin
         case (mon_state_q)
            MON_IDLE: begin
               if (ch0_pos_done && ch0_mon_act_q != 16'h0000) begin // [RULE5]
                  mon_state_q <= MON_WAIT;
                  ms_cnt_q    <= '0;
                  elapsed_q   <= 16'h0000;
               end
            end
            MON_WAIT: begin
               if (ch0_inpos_s || mon_expire) begin
                  mon_state_q <= MON_IDLE;
               end else if (ms_cnt_q == MS_LAST) begin
                  ms_cnt_q  <= '0;
                  elapsed_q <= elapsed_q + 16'h0001;
               end else begin
                  ms_cnt_q <= ms_cnt_q + MS_W'(1);
               end
            end
            default: begin
               mon_state_q <= MON_IDLE;
            end
         endcase
      end
   end

   // sticky, write one to clear; a new timeout in the clearing cycle wins
   assign mon_err_clr = wr_take & (widx == `POCFG_IDX_STATUS) & wb_sel_i[0] & wb_dat_i[`POCFG_S_MON_ERR];

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mon_err_q <= 1'b0;
      end else if (mon_expire) begin
         mon_err_q <= 1'b1;
      end else if (mon_err_clr) begin
         mon_err_q <= 1'b0;
      end
   end

   assign ch0_mon_error = mon_err_q;

   // -----------------------------------------------------------------------------
   // channel 1 limit scope and shared resources
   // -----------------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ch1_stop_q <= 1'b0;
      end else begin
         ch1_stop_q <= (ch1_act[0] | ch1_act[1]) & (ch1_always | ch1_search_busy); // [RULE8]
      end
   end

   assign ch1_lim_stop  = ch1_stop_q;
   assign ch1_search_go = ch1_search_req & ch1_en & init_done_q; // [RULE6]
   assign irq23_allow   = ~ch1_en; // [RULE7]
   assign pwm1_allow    = ~ch1_en; // [RULE7]
   assign hsc01_allow   = 1'b1;    // [RULE7]

   // -----------------------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   sequence mon_arm_s;
      (mon_state_q == MON_IDLE) && ch0_pos_done && (ch0_mon_act_q != 16'h0000);
   endsequence

   sequence mon_fresh_s;
      (mon_state_q == MON_WAIT) && (ms_cnt_q == '0) && (elapsed_q == 16'h0000);
   endsequence

   lim_sense_chk_a: assert property (rstn |=> ch0_cw_lim_act == // [RULE1]
      ($past(lim_open0) ? $past(pins_s[0]) : !$past(pins_s[0]))) else $error("channel 0 limit sense wrong");
   prox_sense_chk_a: assert property (rstn |=> ch0_prox_act == // [RULE2]
      ($past(prox_open0) ? $past(pins_s[2]) : !$past(pins_s[2]))) else $error("channel 0 proximity sense wrong");
   org_sense_chk_a: assert property (rstn |=> ch0_origin_act == // [RULE3]
      ($past(org_open0) ? $past(pins_s[3]) : !$past(pins_s[3]))) else $error("channel 0 origin sense wrong");
   closed_open_a: assert property ((rstn && !lim_open0 && !pins_s[1]) ##1 !lim_open0 |-> ch0_ccw_lim_act) // [RULE11]
      else $error("open circuit not seen as active");
   origin_undef_a: assert property ((ch0_limit_hit && undef0 && !ch0_origin_found) |=> !ch0_origin_defined) // [RULE4]
      else $error("origin kept despite undefine setting");
   origin_hold_a: assert property ((ch0_origin_defined && !undef0) |=> ch0_origin_defined) // [RULE4]
      else $error("origin lost while hold selected");
   cfg_latch_a: assert property (ch0_op_start |=> (ch0_sense_act_q == $past(ch0_sense_q))
                                  && (ch0_mon_act_q == $past(mon_clamped))) // [RULE5]
      else $error("channel 0 settings not latched at start");
   cfg_steady_a: assert property (!ch0_op_start |=> $stable(ch0_sense_act_q) && $stable(ch0_mon_act_q)) // [RULE1]
      else $error("channel 0 settings changed outside start");
   mon_arm_a: assert property (mon_arm_s |=> mon_fresh_s) // [RULE5]
      else $error("monitor did not arm");
   mon_expire_a: assert property (mon_expire |=> ch0_mon_error && (mon_state_q == MON_IDLE)) // [RULE5]
      else $error("monitor timeout not flagged");
   ch1_frozen_a: assert property (init_done_q |=> $stable(ch1_func_act_q)) // [RULE10]
      else $error("channel 1 settings changed after power-up");
   ch1_block_a: assert property (irq23_allow == !ch1_en && pwm1_allow == irq23_allow && hsc01_allow) // [RULE7]
      else $error("shared resource gating wrong");
   ch1_go_a: assert property (ch1_search_go |-> ch1_en) // [RULE6]
      else $error("channel 1 search started while disabled");
   ch1_scope_a: assert property (##1 ch1_lim_stop == $past((ch1_act[0] || ch1_act[1]) && (ch1_always || ch1_search_busy))) // [RULE8]
      else $error("channel 1 limit scope wrong");
   status_mirror_a: assert property ((wb_ack_o && !wb_we_i && widx == `POCFG_IDX_STATUS)
                                     |-> wb_dat_o[3:0] == $past({ch1_act[1], ch1_act[0], ch0_act[1], ch0_act[0]})) // [RULE9]
      else $error("limit status mirror wrong");
   wb_ack_once_a: assert property ((req && !ack_q) |=> wb_ack_o ##1 !wb_ack_o)
      else $error("wishbone ack timing wrong");
endmodule : pocfg_top
`default_nettype wire

// [verification/pocfg_machine_model.sv]
// machine side model: sensor pins and the motor driver in-position answer
`timescale 1ns/100ps
`default_nettype none
module pocfg_machine_model (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rstn,
   // scene set by the bench
   input  wire logic [5:0] lvl,
   input  wire logic       reach,
   input  wire logic       pos_done,
   // pins
   output logic      [5:0] pins,
   output logic            inpos_pin
);
   logic [1:0] settle_q;
   assign pins = lvl;
   // a driver that never reaches the target leaves in-position low, which the monitor must catch
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         settle_q  <= 2'b00;
         inpos_pin <= 1'b0;
      end else begin
         settle_q  <= {settle_q[0], pos_done & reach};
         inpos_pin <= settle_q[1] | (inpos_pin & reach & ~pos_done);
      end
   end
endmodule : pocfg_machine_model
`default_nettype wire

// [verification/pocfg_top_tb.sv]
// self-checking bench for the origin search configuration block
`timescale 1ns/100ps
`default_nettype none
module pocfg_top_tb;
   localparam logic [23:0] ROWS [7] = '{24'h0000_0f, 24'h0111_ff, 24'h0111_00, 24'h0001_0c,
                                        24'h0010_f4, 24'h0100_f8, 24'h0200_0f};
   localparam logic [27:0] RV [5] = '{28'h430_0000, 28'h434_0000, 28'h448_0011, 28'h000_0000, 28'h480_0063};
   logic        core_clk = 1'b0, rstn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [11:0] wb_adr_i = 12'h000;
   logic [3:0]  wb_sel_i = 4'h3;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic [2:0]  pl = 3'h0;
   logic        wb_ack_o, ch0_busy = 1'b0, ch1_search_req = 1'b0, ch1_search_busy = 1'b0, reach = 1'b0;
   logic [5:0]  lvl = 6'h00, pins;
   logic        ch0_inpos_pin, ch0_cw_lim_act, ch0_ccw_lim_act, ch0_prox_act, ch0_origin_act;
   logic        ch0_origin_defined, ch0_mon_error, ch1_search_go, ch1_lim_stop, irq23_allow, pwm1_allow, hsc01_allow;
   int          fail_count = 0, checks_done = 0, n;

   pocfg_top #(.MS_CYCLES(4), .CH1_POWERON_CFG(16'h0011)) DUT (
      .core_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .ch0_cw_lim_pin(pins[0]), .ch0_ccw_lim_pin(pins[1]), .ch0_prox_pin(pins[2]), .ch0_origin_pin(pins[3]),
      .ch0_inpos_pin, .ch1_cw_lim_pin(pins[4]), .ch1_ccw_lim_pin(pins[5]), .ch0_op_start(pl[0]), .ch0_busy,
      .ch0_origin_found(pl[1]), .ch0_pos_done(pl[2]), .ch1_search_req, .ch1_search_busy, .ch0_cw_lim_act,
      .ch0_ccw_lim_act, .ch0_prox_act, .ch0_origin_act, .ch0_origin_defined, .ch0_mon_error, .ch1_search_go,
      .ch1_lim_stop, .irq23_allow, .pwm1_allow, .hsc01_allow);
   pocfg_machine_model MODEL (.core_clk, .rstn, .lvl, .reach, .pos_done(pl[2]), .pins, .inpos_pin(ch0_inpos_pin));

   always #2.5 core_clk = ~core_clk;

   // ---------------------------------------------
   // bus and compare tasks
   // ---------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // ack is read before the edge's own updates land, so it is the value the slave presented
   task wb(input logic we, input logic [11:0] a, input logic [15:0] d);
      n = 0;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= {16'h0, d};
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 40) chk(32'h1, 32'h0);
   endtask : wb

   task pulse(input int i);
      @(posedge core_clk);
      pl[i] <= 1'b1;
      @(posedge core_clk);
      pl[i] <= 1'b0;
   endtask : pulse

   task end_sim;
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim

   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      end_sim();
   end

   initial begin
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge core_clk);
      foreach (RV[i]) begin
         wb(1'b0, RV[i][27:16], 16'h0);
         chk(rd, {16'h0, RV[i][15:0]});
      end
      foreach (ROWS[i]) begin
         wb(1'b1, 12'h430, ROWS[i][23:8]);
         pulse(0);
         lvl[3:0] <= ROWS[i][7:4];
         repeat (6) @(posedge core_clk);
         chk({28'h0, ch0_origin_act, ch0_prox_act, ch0_ccw_lim_act, ch0_cw_lim_act}, {28'h0, ROWS[i][3:0]});
         wb(1'b0, 12'h480, 16'h0);
         chk({30'h0, rd[1:0]}, {30'h0, ROWS[i][1:0]});
      end
      // a new sense word without an operation start must not change anything
      wb(1'b1, 12'h430, 16'h0111);
      repeat (6) @(posedge core_clk);
      chk({28'h0, ch0_origin_act, ch0_prox_act, ch0_ccw_lim_act, ch0_cw_lim_act}, 32'hf);
      chk({29'h0, irq23_allow, pwm1_allow, hsc01_allow}, 32'h1);
      wb(1'b1, 12'h448, 16'h0000);
      wb(1'b0, 12'h480, 16'h0);
      chk({30'h0, rd[6:5]}, 32'h3);
      chk({29'h0, irq23_allow, pwm1_allow, hsc01_allow}, 32'h1);
      ch1_search_req <= 1'b1;
      lvl[4] <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk({30'h0, ch1_search_go, ch1_lim_stop}, 32'h3);
      wb(1'b0, 12'h480, 16'h0);
      chk({31'h0, rd[2]}, 32'h1);
      lvl <= 6'h00;
      wb(1'b1, 12'h430, 16'h1111);
      pulse(0);
      pulse(1);
      repeat (2) @(posedge core_clk);
      chk({31'h0, ch0_origin_defined}, 32'h1);
      ch0_busy <= 1'b1;
      lvl[0] <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk({31'h0, ch0_origin_defined}, 32'h0);
      ch0_busy <= 1'b0;
      wb(1'b1, 12'h430, 16'h0111);
      pulse(0);
      pulse(1);
      ch0_busy <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk({31'h0, ch0_origin_defined}, 32'h1);
      ch0_busy <= 1'b0;
      wb(1'b1, 12'h434, 16'h0002);
      pulse(0);
      pulse(2);
      repeat (14) @(posedge core_clk);
      chk({31'h0, ch0_mon_error}, 32'h1);
      wb(1'b1, 12'h480, 16'h0080);
      @(posedge core_clk);
      chk({31'h0, ch0_mon_error}, 32'h0);
      reach <= 1'b1;
      pulse(2);
      repeat (14) @(posedge core_clk);
      chk({31'h0, ch0_mon_error}, 32'h0);
      // mid-run reset: origin and monitor error clear, channel 1 copy comes back from the power-up word, not the later write
      rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk({28'h0, ch0_origin_defined, ch0_mon_error, irq23_allow, pwm1_allow}, 32'h3);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk({29'h0, irq23_allow, pwm1_allow, hsc01_allow}, 32'h1);
      end_sim();
   end
endmodule : pocfg_top_tb
`default_nettype wire
